// ---- hw/led_pulse_width_generator.sv ----
// Contract
// (RULE1) Frames are 584 bits, highest channel first, each field MSB first.
// (RULE2) Status frame: command nibble, four flags, fault bits, corrections.
// (RULE3) Each serial clock rise shifts one bit; full frame waits for strobe.
// (RULE4) Strobe rise captures and executes the 8-bit command field.
// (RULE5) Same strobe parallel-loads the status frame for shifting out.
// (RULE6) Long strobe high blanks outputs and resets the whole device; the code keeps last_cmd, nol, ol_first and ctrl_blank.
// (RULE7) Host keeps latch-only strobes shorter than the latch maximum.
// (RULE8) Strobe rise ends a frame; first clock after its fall starts one.
// (RULE9) Sync error on strobe with clock high or off a 584 boundary.
// (RULE10) Sync error is informational; next clock starts a new frame.
// (RULE11) Open input sampled per pulse clock, duplicated into all LSBs.
// (RULE12) Self test pulses channels 1..48 for 64 pulse clocks each.
// (RULE13) Next status frame carries per-channel results and test flag.
// (RULE14) Outputs stay low after reset until an enable command.
// (RULE15) Counter reaches one on second pulse clock after enable strobe.
// (RULE16) Without phase shift, nonzero channels rise at counter one.
// (RULE17) A channel falls when the counter matches its active width; the code drops it when the counter reaches rise_at plus the width.
// (RULE18) Disable resets counter at strobe, outputs low next pulse clock.
// (RULE19) Pulse period is 4096 pulse clocks from the rising edge.
// (RULE20) Phase shift toggles; banks rise at 1, 1365 and 2730.
// (RULE21) With correction on, width is scaled 2/3 times (cor+32)/64.
// (RULE22) Corrected width is rounded to nearest whole pulse clock.
// (RULE23) Only the command's upper nibble is decoded; top bit reserved.
// (RULE24) Sync update applies at period start; async applies at strobe.
// (RULE25) Correction frame loads six MSBs per channel, outputs unchanged.
// (RULE26) Blanking clears phase, correction-disable, counter and flags.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
module led_pulse_width_generator #(
  parameter int NUM_CH_P = pwm_gen_pkg::NUM_CH,
  parameter logic [15:0] BLANK_CYC_P = pwm_gen_pkg::BLANK_CYC
) (
  // Clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          resetn_i,
  // Serial frame link
  input  wire logic                          serial_clock_in_i,
  input  wire logic                          serial_data_in_i,
  input  wire logic                          latch_blank_strobe_pin_i,
  output logic                               serial_data_out_o,
  output logic                               serial_clock_out_o,
  // Pulse side
  input  wire logic                          pulse_clock_i,
  input  wire logic                          open_string_input_i,
  output logic [NUM_CH_P-1:0]                pwm_o,
  // APB slave
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [pwm_gen_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic [31:0]                        prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o
);
  import pwm_gen_pkg::*;

  localparam int FL = CH_W * NUM_CH_P + CMD_W;
  localparam int BANK = NUM_CH_P / 3;
  localparam int BC_W = $clog2(FL);
  localparam logic [BC_W-1:0] BC_LAST = BC_W'(FL - 1);
  localparam logic [5:0] CH_LAST = 6'(NUM_CH_P - 1);

  if (NUM_CH_P < 3 || NUM_CH_P > 64 || NUM_CH_P % 3 != 0) begin : g_chk
    $error("NUM_CH_P must be a multiple of 3, at most 64");
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  function automatic logic [CH_W-1:0] scale(input logic [CH_W-1:0] v,
                                            input logic [COR_W-1:0] c,
                                            input logic dis);
    logic [MUL_W-1:0] p;
    p = MUL_W'(v) * (MUL_W'(c) + COR_OFS);
    p = (p + SCALE_RND) / SCALE_DIV;
    scale = dis ? v : p[CH_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and edges

  logic sck_d;
  logic stb_d;
  logic pck_d;
  logic sck_rise;
  logic stb_rise;
  logic pck_rise;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_d <= 1'b0;
      stb_d <= 1'b0;
      pck_d <= 1'b0;
    end else begin
      sck_d <= serial_clock_in_i;
      stb_d <= latch_blank_strobe_pin_i;
      pck_d <= pulse_clock_i;
    end
  end

  assign sck_rise = serial_clock_in_i & ~sck_d;
  assign stb_rise = latch_blank_strobe_pin_i & ~stb_d;
  assign pck_rise = pulse_clock_i & ~pck_d;
  assign serial_clock_out_o = sck_d;

  ////////////////////////////////////////////////////////////////////////////
  // Blanking: strobe held past the threshold resets the device

  logic [CTRL_W-1:0] blank_cnt;
  logic [CTRL_W-1:0] ctrl_blank;
  logic              blank_act;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      blank_cnt <= '0;
    end else if (!latch_blank_strobe_pin_i) begin
      blank_cnt <= '0;
    end else if (blank_cnt != '1) begin
      blank_cnt <= blank_cnt + 1'b1;
    end
  end

  // A short high never reaches the threshold and only latches
  assign blank_act = latch_blank_strobe_pin_i
                     && (blank_cnt >= ctrl_blank); // RULE6 RULE7

  ////////////////////////////////////////////////////////////////////////////
  // Frame shift register and framing

  logic [FL-1:0]       sr;
  logic [FL-1:0]       stat_frame;
  logic [BC_W-1:0]     bit_cnt;
  logic                first_pend;
  logic                ol_samp;
  logic                ol_first;
  logic                sync_err;
  logic                frame_sync_error_flag;
  logic [CMD_HI_W-1:0] last_cmd;
  logic [CMD_HI_W-1:0] cmd_hi;
  logic                exec;

  assign cmd_hi = sr[CMD_W-1 -: CMD_HI_W]; // RULE23
  assign exec = stb_rise && !blank_act; // RULE4
  assign sync_err = serial_clock_in_i || first_pend
                    || (bit_cnt != '0); // RULE9
  assign serial_data_out_o = sr[FL-1];

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sr <= '0;
    end else if (blank_act) begin
      sr <= '0; // RULE6
    end else if (stb_rise) begin
      sr <= stat_frame; // RULE5
    end else if (sck_rise) begin
      sr <= {sr[FL-2:0], serial_data_in_i}; // RULE3 RULE1
    end
  end

  // Framing only reports; the strobe is always trusted as a boundary
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt <= '0;
      first_pend <= 1'b1;
    end else if (blank_act) begin
      bit_cnt <= '0;
      first_pend <= 1'b1;
    end else if (stb_rise) begin
      first_pend <= 1'b1; // RULE8
    end else if (sck_rise) begin
      if (first_pend) begin
        bit_cnt <= BC_W'(1); // RULE10
      end else if (bit_cnt == BC_LAST) begin
        bit_cnt <= '0;
      end else begin
        bit_cnt <= bit_cnt + 1'b1;
      end
      if (!latch_blank_strobe_pin_i) begin
        first_pend <= 1'b0; // RULE8
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_sync_error_flag <= 1'b0;
      last_cmd <= '0;
    end else if (blank_act) begin
      frame_sync_error_flag <= 1'b0; // RULE26
    end else if (stb_rise) begin
      frame_sync_error_flag <= sync_err; // RULE10
      last_cmd <= cmd_hi;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ol_samp <= 1'b0;
      ol_first <= 1'b0;
    end else begin
      if (pck_rise) begin
        ol_samp <= open_string_input_i; // RULE11
      end
      if (sck_rise && first_pend && !latch_blank_strobe_pin_i) begin
        ol_first <= ol_samp; // RULE11
      end
    end
  end

  a_shift_in: assert property ( // RULE3
    sck_rise && !stb_rise && !blank_act |=> sr[0] == $past(serial_data_in_i))
    else $error("serial bit not shifted in");

  a_sync_flag: assert property ( // RULE9
    stb_rise && !blank_act && (serial_clock_in_i || bit_cnt != '0) |=> frame_sync_error_flag)
    else $error("sync error flag not set");

  ////////////////////////////////////////////////////////////////////////////
  // Mode settings

  logic bank_phase_shift_flag;
  logic correction_disable_flag;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bank_phase_shift_flag <= 1'b0;
      correction_disable_flag <= 1'b0;
    end else if (blank_act) begin
      bank_phase_shift_flag <= 1'b0; // RULE26
      correction_disable_flag <= 1'b0;
    end else if (exec && cmd_hi == CMD_PHS) begin
      bank_phase_shift_flag <= ~bank_phase_shift_flag; // RULE20
    end else if (exec && cmd_hi == CMD_CRDT) begin
      correction_disable_flag <= ~correction_disable_flag; // RULE23
    end
  end

  a_crd_toggle: assert property ( // RULE23
    exec && cmd_hi == CMD_CRDT |=> correction_disable_flag != $past(correction_disable_flag))
    else $error("correction toggle ignored");

  ////////////////////////////////////////////////////////////////////////////
  // Pulse counter and output enable

  en_state_t        en_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             go;
  logic             period_start;
  logic             sync_pend;

  assign go = pck_rise && (en_state == EN_RUN || en_state == EN_ARM2);
  assign next_cnt = (en_state == EN_RUN) ? cnt + 1'b1 : CNT_START;
  assign period_start = go && next_cnt == CNT_START; // RULE19

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_state <= EN_OFF; // RULE14
      cnt <= '0;
    end else if (blank_act) begin
      en_state <= EN_OFF; // RULE26
      cnt <= '0;
    end else if (exec && cmd_hi == CMD_DIS) begin
      en_state <= EN_OFF; // RULE18
      cnt <= '0;
    end else if (exec && cmd_hi == CMD_EN && en_state == EN_OFF) begin
      en_state <= EN_ARM1;
      cnt <= '0;
    end else if (pck_rise) begin
      case (en_state)
        EN_ARM1: en_state <= EN_ARM2;
        EN_ARM2: begin
          en_state <= EN_RUN; // RULE15
          cnt <= CNT_START;
        end
        EN_RUN: cnt <= next_cnt; // RULE19
        default: en_state <= EN_OFF;
      endcase
    end
  end

  // Set wins over the consuming period start
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_pend <= 1'b0;
    end else if (blank_act) begin
      sync_pend <= 1'b0;
    end else if (exec && cmd_hi == CMD_SYNC) begin
      sync_pend <= 1'b1; // RULE24
    end else if (period_start) begin
      sync_pend <= 1'b0;
    end
  end

  // Arming took the first pulse clock; the second one must start counting
  a_enable_one: assert property ( // RULE15
    en_state == EN_ARM2 && pck_rise && !exec && !blank_act
    |=> cnt == CNT_START && en_state == EN_RUN)
    else $error("counter not one on second pulse clock");

  a_disable_now: assert property ( // RULE18
    exec && cmd_hi == CMD_DIS |=> cnt == '0 && en_state == EN_OFF)
    else $error("disable did not reset counter");

  a_period_wrap: assert property ( // RULE19
    en_state == EN_RUN && pck_rise && cnt == CNT_LAST && !stb_rise
    && !blank_act |=> cnt == '0)
    else $error("counter did not wrap at 4096");

  ////////////////////////////////////////////////////////////////////////////
  // Self test sequencer

  test_state_t t_state;
  logic [5:0]  t_ch;
  logic [5:0]  t_cnt;
  logic        t_finish;
  logic        st_done;

  assign t_finish = t_state == T_RUN && pck_rise && t_cnt == TEST_LAST
                    && t_ch == CH_LAST;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      t_state <= T_IDLE;
      t_ch <= '0;
      t_cnt <= '0;
    end else if (blank_act) begin
      t_state <= T_IDLE;
    end else if (exec && cmd_hi == CMD_TEST) begin
      t_state <= T_RUN; // RULE12
      t_ch <= '0;
      t_cnt <= '0;
    end else begin
      case (t_state)
        T_RUN: begin
          if (pck_rise) begin
            t_cnt <= t_cnt + 1'b1;
            if (t_cnt == TEST_LAST && t_ch == CH_LAST) begin
              t_state <= T_IDLE;
            end else if (t_cnt == TEST_LAST) begin
              t_ch <= t_ch + 1'b1; // RULE12
            end
          end
        end
        default: t_state <= T_IDLE;
      endcase
    end
  end

  // Results hold until the next status load; a finish beats that load
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_done <= 1'b0;
    end else if (blank_act) begin
      st_done <= 1'b0; // RULE26
    end else if (t_finish) begin
      st_done <= 1'b1; // RULE13
    end else if (stb_rise) begin
      st_done <= 1'b0; // RULE13
    end
  end

  a_test_onehot: assert property ( // RULE12
    t_state == T_RUN && !blank_act |=> $onehot(pwm_o))
    else $error("self test drives other than one channel");

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel width, correction and output

  assign stat_frame[CMD_W-1:0] = {cmd_hi, st_done, sync_err, bank_phase_shift_flag, correction_disable_flag};

  for (genvar i = 0; i < NUM_CH_P; i++) begin : g_ch
    localparam logic [CNT_W-1:0] PH = (i >= 2 * BANK) ? CNT_START :
                                      (i >= BANK) ? CNT_PH1 : CNT_PH2;
    logic [CH_W-1:0]  fld;
    logic [CH_W-1:0]  corr;
    logic [CH_W-1:0]  stg;
    logic [CH_W-1:0]  act;
    logic [COR_W-1:0] cor;
    logic [CNT_W-1:0] rise_at;
    logic [CNT_W-1:0] fall_at;
    logic             nol;
    logic             pwm_q;

    assign fld = sr[CMD_W + CH_W * i +: CH_W]; // RULE1
    assign corr = scale(fld, cor, correction_disable_flag); // RULE21 RULE22
    assign rise_at = bank_phase_shift_flag ? PH : CNT_START; // RULE20 RULE16
    assign fall_at = CNT_W'(rise_at + act);
    assign stat_frame[CMD_W + CH_W * i +: CH_W] =
      {cor, {(CH_W - COR_W - 1){1'b0}}, st_done ? nol : ol_first}; // RULE2
    assign pwm_o[i] = pwm_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        cor <= COR_RESET;
      end else if (blank_act) begin
        cor <= COR_RESET;
      end else if (exec && cmd_hi == CMD_COR) begin
        cor <= fld[CH_W-1 -: COR_W]; // RULE25
      end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        stg <= '0;
        act <= '0;
      end else if (blank_act) begin
        stg <= '0;
        act <= '0;
      end else if (exec && cmd_hi == CMD_SYNC) begin
        stg <= corr; // RULE24
      end else if (exec && cmd_hi == CMD_ASYNC) begin
        stg <= corr; // RULE24
        act <= corr;
      end else if (period_start && sync_pend) begin
        act <= stg; // RULE24
      end
    end

    // Fall compares against the value the counter takes at this edge, so the
    // output is high while the counter shows rise_at .. rise_at+act-1
    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        pwm_q <= 1'b0; // RULE14
      end else if (blank_act) begin
        pwm_q <= 1'b0; // RULE6
      end else if (t_state == T_RUN) begin
        pwm_q <= (t_ch == 6'(i)); // RULE12
      end else if (pck_rise) begin
        if (!go) begin
          pwm_q <= 1'b0; // RULE18
        end else if (next_cnt == rise_at && act != '0) begin
          pwm_q <= 1'b1; // RULE16 RULE20
        end else if (next_cnt == fall_at) begin
          pwm_q <= 1'b0; // RULE17
        end
      end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        nol <= 1'b0;
      end else if (t_state == T_RUN && pck_rise && t_ch == 6'(i)
                   && t_cnt == TEST_LAST) begin
        nol <= ol_samp; // RULE12
      end
    end
  end

  a_blank_low: assert property ( // RULE6
    blank_act |=> pwm_o == '0 && sr == '0)
    else $error("blanking left outputs or shift register set");

  a_status_load: assert property ( // RULE5
    stb_rise && !blank_act |=> sr[CMD_W-1 -: CMD_HI_W] == $past(cmd_hi)
    && sr[CMD_W + COR_W +: COR_W] == $past(g_ch[0].cor))
    else $error("status frame not loaded on strobe");

  a_width_fall: assert property ( // RULE17
    t_state == T_IDLE && go && !blank_act && !bank_phase_shift_flag
    && g_ch[0].act != '0 && next_cnt == g_ch[0].fall_at
    && next_cnt != CNT_START |=> !pwm_o[0])
    else $error("channel did not fall at its width");

  a_sync_apply: assert property ( // RULE24
    period_start && sync_pend && !exec && !blank_act
    |=> g_ch[0].act == $past(g_ch[0].stg))
    else $error("staged width not applied at period start");

  ////////////////////////////////////////////////////////////////////////////
  // APB registers

  logic hit;

  assign hit = paddr_i == A_CTRL || paddr_i == A_STAT;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_blank <= BLANK_CYC_P;
    end else if (psel_i && penable_i && pwrite_i && paddr_i == A_CTRL) begin
      ctrl_blank <= pwdata_i[CTRL_W-1:0];
    end
  end

  // Read data is taken in the setup cycle so no wait state is needed
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= '0;
    end else if (psel_i && !penable_i) begin
      case (paddr_i)
        A_CTRL: prdata_o <= 32'(ctrl_blank);
        A_STAT: prdata_o <= 32'({t_state == T_RUN, en_state == EN_RUN,
                                 st_done, frame_sync_error_flag, bank_phase_shift_flag, correction_disable_flag, last_cmd});
        default: prdata_o <= '0;
      endcase
    end
  end

endmodule

// ---- hw/pwm_gen_pkg.sv ----
package pwm_gen_pkg;

  localparam int NUM_CH = 48;
  localparam int CH_W = 12;
  localparam int COR_W = 6;
  localparam int CMD_W = 8;
  localparam int CMD_HI_W = 4;
  localparam int CNT_W = 12;
  localparam int MUL_W = 21;
  localparam int FRAME_LEN = CH_W * NUM_CH + CMD_W;

  // Pulse counter landmarks
  localparam logic [CNT_W-1:0] CNT_START = 12'h001;
  localparam logic [CNT_W-1:0] CNT_PH1   = 12'h555;
  localparam logic [CNT_W-1:0] CNT_PH2   = 12'hAAA;
  localparam logic [CNT_W-1:0] CNT_LAST  = 12'hFFF;

  // Self test dwell: 64 pulse clocks per channel
  localparam logic [5:0] TEST_LAST = 6'h3F;

  // Width scaling: v * (cor + 32) * 2 / 3 / 64, rounded
  localparam logic [MUL_W-1:0] COR_OFS   = 21'h000020;
  localparam logic [MUL_W-1:0] SCALE_RND = 21'h000030;
  localparam logic [MUL_W-1:0] SCALE_DIV = 21'h000060;
  localparam logic [COR_W-1:0] COR_RESET = 6'h20;

  // Blanking threshold on the strobe pin
  localparam int CTRL_W = 16;
  localparam int CLK_PERIOD_NS = 50;
  localparam int BLANK_MIN_NS = 2000;
  localparam logic [CTRL_W-1:0] BLANK_CYC =
    16'((BLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Command codes (upper nibble of the command field)
  localparam logic [3:0] CMD_SYNC  = 4'h0;
  localparam logic [3:0] CMD_ASYNC = 4'h1;
  localparam logic [3:0] CMD_COR   = 4'h2;
  localparam logic [3:0] CMD_EN    = 4'h3;
  localparam logic [3:0] CMD_DIS   = 4'h4;
  localparam logic [3:0] CMD_TEST  = 4'h5;
  localparam logic [3:0] CMD_PHS   = 4'h6;
  localparam logic [3:0] CMD_CRDT  = 4'h7;

  // APB map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h04;

  typedef enum logic [1:0] {EN_OFF, EN_ARM1, EN_ARM2, EN_RUN} en_state_t;
  typedef enum logic {T_IDLE, T_RUN} test_state_t;

endpackage

// ---- test/frame_host.sv ----
module frame_host (
  // Clock
  input  wire logic         mclk_i,
  // Serial link towards the device
  output logic              sclk_o,
  output logic              sdi_o,
  output logic              strobe_o,
  input  wire logic         sdo_i,
  input  wire logic         serial_clock_out_i
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [583:0] rx;
  int           sck_bad;

  initial begin
    sck_bad = 0;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    strobe_o = 1'b0;
    rx = '0;
  end

  // Sends the low n bits of f, top bit first; the device reads at
  // least two mclk per clock level, so each level lasts two cycles.
  task automatic send(input logic [583:0] f, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o <= f[i];
      repeat (2) @(posedge mclk_i);
      sclk_o <= 1'b1;
      rx[i] = sdo_i;
      // Forwarded clock trails ours by one mclk
      if (serial_clock_out_i !== 1'b0) sck_bad++;
      repeat (2) @(posedge mclk_i);
      if (serial_clock_out_i !== 1'b1) sck_bad++;
      sclk_o <= 1'b0;
    end
    repeat (2) @(posedge mclk_i);
    // Short strobe only, well below the blanking threshold
    strobe_o <= 1'b1;
    repeat (3) @(posedge mclk_i);
    strobe_o <= 1'b0;
    // Released data line must not look like a held bit
    sdi_o <= ~sdi_o;
    repeat (2) @(posedge mclk_i);
  endtask

  task automatic blank(input int n);
    strobe_o <= 1'b1;
    repeat (n) @(posedge mclk_i);
    strobe_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule

// ---- test/test_led_pulse_width_generator.sv ----
module test_led_pulse_width_generator;
  timeunit 1ns;
  timeprecision 1ns;
  import pwm_gen_pkg::*;

  logic        mclk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        sclk, serial_data_in, strobe, serial_data_out, serial_clock_out;
  logic        open_in = 1'b1;
  logic [1:0]  pdiv = 2'h0;
  logic [47:0] pwm_o;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, r;
  logic        pready_o, pslverr_o, e;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          n;

  always #25 mclk_i = ~mclk_i;
  // Pulse clock at a quarter of mclk, as the design samples it
  always @(posedge mclk_i) pdiv <= pdiv + 2'h1;
  // Open flag reads open except while channel 2 is driven
  always @(posedge mclk_i) open_in <= ~pwm_o[1];

  led_pulse_width_generator i_dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i),
    .serial_clock_in_i(sclk), .serial_data_in_i(serial_data_in),
    .latch_blank_strobe_pin_i(strobe), .serial_data_out_o(serial_data_out),
    .serial_clock_out_o(serial_clock_out), .pulse_clock_i(pdiv[1]),
    .open_string_input_i(open_in), .pwm_o(pwm_o),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o));

  frame_host i_host (.mclk_i(mclk_i), .sclk_o(sclk), .sdi_o(serial_data_in),
    .strobe_o(strobe), .sdo_i(serial_data_out), .serial_clock_out_i(serial_clock_out));

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Idle cycle so a following call never reassigns in the same step
    @(posedge mclk_i);
  endtask

  function automatic logic [583:0] fr(input logic [7:0] c,
                                      input logic [11:0] v1);
    fr = '0;
    fr[7:0] = c;
    fr[19:8] = v1;
  endfunction

  // High time of channel 1 in mclk cycles; the watchdog ends a hang
  task automatic width1();
    n = 0;
    while (pwm_o[0] !== 1'b1) @(posedge mclk_i);
    while (pwm_o[0] === 1'b1) begin
      n++;
      @(posedge mclk_i);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_apb();
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, A_CTRL, 32'h28);
    apb(1'b0, A_CTRL, 32'h0);
    chk(r, 32'h28);
    $display("test apb done");
  endtask

  task automatic t_status();
    chk(pwm_o, 48'h0);
    i_host.send(fr(8'h30, 12'h0), 584);
    chk(pwm_o, 48'h0);
    i_host.send(fr(8'h40, 12'h0), 584);
    chk(i_host.rx[7:0], 8'h30);
    chk(i_host.rx[583:572], 12'h801);
    chk(i_host.sck_bad, 48'h0);
    $display("test status done");
  endtask

  task automatic t_raw_width();
    i_host.send(fr(8'h70, 12'h0), 584);
    i_host.send(fr(8'h10, 12'h3), 584);
    i_host.send(fr(8'h30, 12'h0), 584);
    width1();
    chk(n, 12);
    apb(1'b0, A_STAT, 32'h0);
    chk(r[4], 1'b1);
    i_host.send(fr(8'h40, 12'h0), 584);
    repeat (12) @(posedge mclk_i);
    chk(pwm_o, 48'h0);
    $display("test raw width done");
  endtask

  task automatic t_sync();
    i_host.send(fr(8'h40, 12'h0), 10);
    apb(1'b0, A_STAT, 32'h0);
    chk(r[6], 1'b1);
    i_host.send(fr(8'h70, 12'h0), 584);
    apb(1'b0, A_STAT, 32'h0);
    chk(r[6:4], 3'h0);
    $display("test sync done");
  endtask

  task automatic t_blank();
    i_host.send(fr(8'h60, 12'h0), 584);
    apb(1'b0, A_STAT, 32'h0);
    chk(r[5], 1'b1);
    // Run the counter; the blanking strobe re-executes only an enable
    i_host.send(fr(8'h30, 12'h0), 584);
    repeat (8) @(posedge mclk_i);
    apb(1'b0, A_STAT, 32'h0);
    chk(r[8], 1'b1);
    i_host.blank(60);
    apb(1'b0, A_STAT, 32'h0);
    chk(r[8], 1'b0);
    chk(r[5:4], 2'h0);
    chk(serial_data_out, 1'b0);
    chk(pwm_o, 48'h0);
    $display("test blank done");
  endtask

  task automatic t_corr();
    i_host.send(fr(8'h20, 12'hFC0), 584);
    chk(pwm_o, 48'h0);
    // Staged width lands at the period start that enable opens
    i_host.send(fr(8'h00, 12'd120), 584);
    i_host.send(fr(8'h30, 12'h0), 584);
    width1();
    chk(n, 119 * 4);
    $display("test correction done");
  endtask

  task automatic t_self();
    i_host.send(fr(8'h50, 12'h0), 584);
    apb(1'b0, A_STAT, 32'h0);
    chk(r[9], 1'b1);
    do apb(1'b0, A_STAT, 32'h0); while (r[9] !== 1'b0);
    chk(r[7], 1'b1);
    i_host.send(fr(8'h40, 12'h0), 584);
    i_host.send(fr(8'h40, 12'h0), 584);
    chk(i_host.rx[7:0], 8'h48);
    chk(i_host.rx[31:8], 24'h000FC1);
    i_host.send(fr(8'h40, 12'h0), 584);
    chk(i_host.rx[7:0], 8'h40);
    chk(i_host.rx[31:8], 24'h001FC1);
    $display("test self test done");
  endtask

  initial begin
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    t_apb();
    t_status();
    t_raw_width();
    t_sync();
    t_blank();
    t_corr();
    t_self();
    end_sim();
  end

  // A clean run takes about 67000 cycles
  initial begin
    repeat (95000) @(posedge mclk_i);
    error_cnt++;
    end_sim();
  end
endmodule
